// [logic/czb_defines.vh]
// constants for the compact zero-test branch and breakpoint decoder
`ifndef CZB_DEFINES_VH
`define CZB_DEFINES_VH

// instruction fields
`define CZB_MAJ_HI        15
`define CZB_MAJ_LO        11
`define CZB_PFX_HI        31
`define CZB_PFX_LO        27
`define CZB_PREFIX        5'h1e
`define CZB_OP_REQZ       5'h04
`define CZB_OP_RNEZ       5'h05
`define CZB_OP_IMM_GROUP  5'h0c
`define CZB_OP_UNCOND     5'h02
`define CZB_OP_REG_PAIR   5'h1d
`define CZB_FN_TEST_ZERO  3'h0
`define CZB_FN_TEST_NZ    3'h1
`define CZB_FN_BREAK      5'h05

// implicit test-result register number
`define CZB_TEST_GPR      5'h18

// sequential step sizes in bytes
`define CZB_STEP_SHORT    32'h0000_0002
`define CZB_STEP_EXT      32'h0000_0004

// decoded operation kinds
`define CZB_K_NONE        3'h0
`define CZB_K_REQZ        3'h1
`define CZB_K_RNEZ        3'h2
`define CZB_K_TEQZ        3'h3
`define CZB_K_TNEZ        3'h4
`define CZB_K_UNCOND      3'h5
`define CZB_K_BREAK       3'h6

// sequencer states
`define CZB_S_IDLE        1'b0
`define CZB_S_READ        1'b1

`endif

// [logic/czb_decode.v]
// field decoder for zero-test branches and the breakpoint instruction
`timescale 1ns/1ps
`default_nettype none
`include "czb_defines.vh"

module czb_decode (
    input  wire [31:0] instr_i,   // upper half is prefix when ext_i
    input  wire        ext_i,     // instruction carries the prefix
    output reg  [2:0]  kind_o,    // decoded operation kind
    output wire [2:0]  rsel_o,    // register selector field
    output reg  [31:0] disp_o     // scaled sign-extended displacement
);

    wire [4:0]  major;
    wire [4:0]  prefix;
    wire [2:0]  fn;
    wire        low_zero;
    wire        pfx_ok;
    wire [15:0] off16;

    assign major    = instr_i[`CZB_MAJ_HI:`CZB_MAJ_LO];
    assign prefix   = instr_i[`CZB_PFX_HI:`CZB_PFX_LO];
    assign fn       = instr_i[10:8];
    assign rsel_o   = instr_i[10:8];
    assign low_zero = (instr_i[7:5] == 3'h0);
    assign pfx_ok   = ext_i && (prefix == `CZB_PREFIX);
    // extended offset is scattered over three fields
    assign off16    = {instr_i[20:16], instr_i[26:21], instr_i[4:0]};

    // shift left one bit, then sign-extend to full width
    function [31:0] sext_scaled;
        input [15:0] off;
        input        wide;
        begin
            if (wide) begin
                sext_scaled = {{15{off[15]}}, off, 1'b0};
            end else begin
                sext_scaled = {{23{off[7]}}, off[7:0], 1'b0};
            end
        end
    endfunction

    always @* begin
        kind_o = `CZB_K_NONE;
        disp_o = sext_scaled(off16, 1'b1);
        if (!ext_i) begin
            disp_o = sext_scaled({8'h00, instr_i[7:0]}, 1'b0);
            case (major)
                `CZB_OP_REQZ: kind_o = `CZB_K_REQZ;
                `CZB_OP_RNEZ: kind_o = `CZB_K_RNEZ;
                `CZB_OP_IMM_GROUP: begin
                    if (fn == `CZB_FN_TEST_ZERO) begin
                        kind_o = `CZB_K_TEQZ;
                    end else if (fn == `CZB_FN_TEST_NZ) begin
                        kind_o = `CZB_K_TNEZ;
                    end
                end
                `CZB_OP_REG_PAIR: begin
                    if (instr_i[4:0] == `CZB_FN_BREAK) begin
                        kind_o = `CZB_K_BREAK;
                    end
                end
                default: kind_o = `CZB_K_NONE;
            endcase
        end else if (pfx_ok) begin
            case (major)
                `CZB_OP_REQZ: begin
                    if (low_zero) kind_o = `CZB_K_REQZ;
                end
                `CZB_OP_RNEZ: begin
                    if (low_zero) kind_o = `CZB_K_RNEZ;
                end
                `CZB_OP_IMM_GROUP: begin
                    if (low_zero && fn == `CZB_FN_TEST_ZERO) begin
                        kind_o = `CZB_K_TEQZ;
                    end else if (low_zero && fn == `CZB_FN_TEST_NZ) begin
                        kind_o = `CZB_K_TNEZ;
                    end
                end
                `CZB_OP_UNCOND: begin
                    if (instr_i[10:5] == 6'h00) begin
                        kind_o = `CZB_K_UNCOND;
                    end
                end
                default: kind_o = `CZB_K_NONE;
            endcase
        end
    end

endmodule // czb_decode
`default_nettype wire

// [logic/czb_branch_unit.v]
// zero-test conditional branch and breakpoint execution unit
`timescale 1ns/1ps
`default_nettype none
`include "czb_defines.vh"

module czb_branch_unit (
    input  wire        clk_i,        // core clock, 50 MHz
    input  wire        nrst_i,       // asynchronous reset, active low
    input  wire        inst_valid_i, // instruction offered this cycle
    input  wire [31:0] inst_i,       // instruction, prefix in upper half
    input  wire        inst_ext_i,   // upper half holds the prefix
    input  wire [31:0] inst_pc_i,    // address of the instruction
    input  wire [31:0] rd_data_i,    // register value for rd_addr_o
    output reg         ready_o,      // unit can take an instruction
    output reg         rd_en_o,      // register read request
    output reg  [4:0]  rd_addr_o,    // register number to read
    output reg         rd_xlat_o,    // rd_addr_o low bits need translation
    output reg         done_o,       // branch resolved, one-cycle pulse
    output reg         taken_o,      // branch taken, valid with done_o
    output reg  [31:0] next_pc_o,    // next pc, valid with done_o
    output reg         brk_o,        // breakpoint exception pulse
    output reg  [31:0] brk_pc_o,     // pc of the breakpoint instruction
    output reg         unknown_o     // instruction not handled here, pulse
);

    wire [2:0]  dec_kind;
    wire [2:0]  dec_rsel;
    wire [31:0] dec_disp;

    reg         state_q;
    reg         state_d;
    reg  [2:0]  kind_q;
    reg  [31:0] tgt_q;
    reg  [31:0] seq_q;

    reg         cond;
    wire        accept;
    wire [31:0] step;

    czb_decode u_dec (
        .instr_i (inst_i),
        .ext_i   (inst_ext_i),
        .kind_o  (dec_kind),
        .rsel_o  (dec_rsel),
        .disp_o  (dec_disp)
    );

    assign accept = inst_valid_i && ready_o && (state_q == `CZB_S_IDLE);
    assign step   = inst_ext_i ? `CZB_STEP_EXT : `CZB_STEP_SHORT;

    // branch condition: zero test on the returned register value, constant true for an unconditional jump
    always @* begin
        case (kind_q)
            `CZB_K_REQZ:   cond = (rd_data_i == 32'h0000_0000);
            `CZB_K_RNEZ:   cond = (rd_data_i != 32'h0000_0000);
            `CZB_K_TEQZ:   cond = (rd_data_i == 32'h0000_0000);
            `CZB_K_TNEZ:   cond = (rd_data_i != 32'h0000_0000);
            `CZB_K_UNCOND: cond = 1'b1;
            default:       cond = 1'b0;
        endcase
    end

    always @* begin
        state_d = state_q;
        case (state_q)
            `CZB_S_IDLE: begin
                if (accept && dec_kind != `CZB_K_NONE &&
                    dec_kind != `CZB_K_BREAK) begin
                    state_d = `CZB_S_READ;
                end
            end
            `CZB_S_READ: state_d = `CZB_S_IDLE;
            default:     state_d = `CZB_S_IDLE;
        endcase
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q   <= `CZB_S_IDLE;
            kind_q    <= `CZB_K_NONE;
            tgt_q     <= 32'h0000_0000;
            seq_q     <= 32'h0000_0000;
            ready_o   <= 1'b1;
            rd_en_o   <= 1'b0;
            rd_addr_o <= 5'h00;
            rd_xlat_o <= 1'b0;
            done_o    <= 1'b0;
            taken_o   <= 1'b0;
            next_pc_o <= 32'h0000_0000;
            brk_o     <= 1'b0;
            brk_pc_o  <= 32'h0000_0000;
            unknown_o <= 1'b0;
        end else begin
            state_q   <= state_d;
            done_o    <= 1'b0;
            brk_o     <= 1'b0;
            unknown_o <= 1'b0;
            rd_en_o   <= 1'b0;
            case (state_q)
                `CZB_S_IDLE: begin
                    if (accept) begin
                        kind_q <= dec_kind;
                        // target relative to the following instruction
                        tgt_q  <= inst_pc_i + step + dec_disp;
                        seq_q  <= inst_pc_i + step;
                        case (dec_kind)
                            `CZB_K_NONE: unknown_o <= 1'b1;
                            `CZB_K_BREAK: begin
                                // no code-field path; handler rereads memory
                                brk_o    <= 1'b1;
                                brk_pc_o <= inst_pc_i;
                            end
                            `CZB_K_TEQZ, `CZB_K_TNEZ: begin
                                ready_o   <= 1'b0;
                                rd_en_o   <= 1'b1;
                                rd_addr_o <= `CZB_TEST_GPR;
                                rd_xlat_o <= 1'b0;
                            end
                            `CZB_K_REQZ, `CZB_K_RNEZ: begin
                                ready_o   <= 1'b0;
                                rd_en_o   <= 1'b1;
                                rd_addr_o <= {2'b00, dec_rsel};
                                rd_xlat_o <= 1'b1;
                            end
                            default: begin
                                ready_o <= 1'b0;
                            end
                        endcase
                    end
                end
                `CZB_S_READ: begin
                    ready_o   <= 1'b1;
                    done_o    <= 1'b1;
                    taken_o   <= cond;
                    // untaken path falls through without any exception
                    next_pc_o <= cond ? tgt_q : seq_q;
                end
                default: begin
                    ready_o <= 1'b1;
                end
            endcase
        end
    end

endmodule // czb_branch_unit
`default_nettype wire

// [bench/czb_branch_unit_assertions.sv]
// assertions on the zero-test branch unit ports
`timescale 1ns/1ps
`default_nettype none
module czb_branch_unit_assertions (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        inst_valid_i,
    input wire logic [31:0] inst_i,
    input wire logic        inst_ext_i,
    input wire logic [31:0] rd_data_i,
    input wire logic        ready_o,
    input wire logic        rd_en_o,
    input wire logic [4:0]  rd_addr_o,
    input wire logic        done_o,
    input wire logic        taken_o,
    input wire logic        brk_o,
    input wire logic        unknown_o
);
    wire [4:0] op = inst_i[15:11];
    wire acc = inst_valid_i & ready_o;
    wire px = acc & inst_ext_i & inst_i[31:27] == 5'h1e;
    // accepted short form or well-formed prefixed form
    wire ok = acc & ~inst_ext_i | px & inst_i[7:5] == 3'h0;
    wire rb = ok & op[4:1] == 4'h2;
    wire tb = ok & op == 5'h0c & inst_i[10:9] == 2'h0;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_read; !ready_o && rd_en_o; endsequence
    sequence s_done; done_o && ready_o && !brk_o && !unknown_o; endsequence
    AST_RESOLVE: assert property (rb || tb |=> s_read ##1 s_done)
        else $error("branch not resolved on time");
    AST_REG_SEL: assert property (rb |=>
        rd_addr_o == {2'h0, $past(inst_i[10:8])}) else $error("selector lost");
    AST_TEST_SEL: assert property (tb |=> rd_addr_o == 5'h18)
        else $error("test register not read");
    AST_REG_COND: assert property (rb |=> ##1
        taken_o == (($past(rd_data_i) == 0) ^ $past(inst_i[11], 2)))
        else $error("register condition wrong");
    AST_TEST_COND: assert property (tb |=> ##1
        taken_o == (($past(rd_data_i) == 0) ^ $past(inst_i[8], 2)))
        else $error("test condition wrong");
    AST_UNCOND: assert property (
        px && op == 5'h02 && inst_i[10:5] == 6'h0
        |=> !rd_en_o ##1 done_o && taken_o) else $error("jump not taken");
    AST_BREAK: assert property (
        acc && !inst_ext_i && op == 5'h1d && inst_i[4:0] == 5'h05
        |=> brk_o && !rd_en_o && !unknown_o) else $error("breakpoint missed");
    AST_EXT_RSVD: assert property (px && inst_i[7:5] != 3'h0 |=>
        unknown_o && !rd_en_o) else $error("bad prefixed form accepted");
endmodule // czb_branch_unit_assertions
bind czb_branch_unit czb_branch_unit_assertions
    i_czb_branch_unit_assertions (.*);
`default_nettype wire

// [bench/czb_regfile_model.sv]
// register file stand-in answering the unit's read requests
`timescale 1ns/1ps
`default_nettype none
module czb_regfile_model (
    input  wire logic        clk_i,     // core clock
    input  wire logic        rd_en_i,   // read request
    input  wire logic [4:0]  rd_addr_i, // register number
    output logic      [31:0] rd_data_o  // register value
);
    logic [31:0] gpr [0:31];
    logic [31:0] idle_q = 32'h5a5a_a5a5;
    // no read pending: toggle so stale data never looks valid
    always @(posedge clk_i) idle_q <= ~idle_q;
    assign rd_data_o = rd_en_i ? gpr[rd_addr_i] : idle_q;
endmodule // czb_regfile_model
`default_nettype wire

// [bench/czb_branch_unit_bench.sv]
// self-checking bench for the zero-test branch unit
`timescale 1ns/1ps
`default_nettype none
module czb_branch_unit_bench;
    logic        clk_i = 1'h0, nrst_i = 1'h0;
    logic        inst_valid_i = 1'h0, inst_ext_i = 1'h0;
    logic [31:0] inst_i = 32'h0, inst_pc_i = 32'h0;
    wire         ready_o, rd_en_o, rd_xlat_o, done_o, taken_o, brk_o, unknown_o;
    wire  [4:0]  rd_addr_o;
    wire  [31:0] rd_data_i, next_pc_o, brk_pc_o;
    int          mismatches = 0, samples_checked = 0;
    czb_branch_unit i_czb_branch_unit (.*);
    czb_regfile_model i_czb_regfile_model (.clk_i(clk_i), .rd_en_i(rd_en_o),
        .rd_addr_i(rd_addr_o), .rd_data_o(rd_data_i));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic stop_test;
        $display("mismatches %0d checks %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // offer one instruction; returns one cycle after it was offered
    task automatic issue(input logic [31:0] w, pc);
        inst_valid_i = 1'h1;
        inst_i = w;
        inst_ext_i = w[31:27] == 5'h1e;
        inst_pc_i = pc;
        @(negedge clk_i);
    endtask
    task automatic br(input logic [31:0] w, pc, input logic [4:0] rn,
                      input logic [31:0] rv, np, input logic tk);
        i_czb_regfile_model.gpr[rn] = rv;
        issue(w, pc);
        inst_valid_i = 1'h0;
        // read request stands in the cycle after the accept
        chk({31'h0, ready_o}, 32'h0);
        chk({31'h0, rd_en_o}, {31'h0, w[15:11] != 5'h02});
        chk({27'h0, rd_addr_o}, {27'h0, rn});
        chk({31'h0, rd_xlat_o}, {31'h0, rn != 5'h18});
        @(negedge clk_i);
        chk({31'h0, done_o}, 32'h1);
        chk({31'h0, taken_o}, {31'h0, tk});
        chk(next_pc_o, np);
    endtask
    task automatic t_cond;
        i_czb_regfile_model.gpr[0] = 32'h1;
        br(32'h2380, 32'h1000, 5'h3, 32'h0, 32'h0f02, 1'h1);
        br(32'h2380, 32'h1000, 5'h3, 32'h8000_0000, 32'h1002, 1'h0);
        br(32'h2d7f, 32'h2000, 5'h5, 32'h8000_0000, 32'h2100, 1'h1);
        br(32'h2d7f, 32'h2000, 5'h5, 32'h0, 32'h2002, 1'h0);
        br(32'h6010, 32'h3000, 5'h18, 32'h0, 32'h3022, 1'h1);
        br(32'h6110, 32'h3000, 5'h18, 32'h0, 32'h3002, 1'h0);
        br(32'h6010, 32'h3000, 5'h18, 32'h7, 32'h3002, 1'h0);
        br(32'h6110, 32'h3000, 5'h18, 32'h7, 32'h3022, 1'h1);
    endtask
    task automatic t_ext;
        br(32'hf010_2201, 32'h0001_0000, 5'h2, 32'h0, 32'h6, 1'h1);
        br(32'hf7ef_2e1f, 32'h100, 5'h6, 32'h1, 32'h0001_0102, 1'h1);
        br(32'hf7ef_611f, 32'h100, 5'h18, 32'h0, 32'h104, 1'h0);
        br(32'hf000_1004, 32'h200, 5'h18, 32'h0, 32'h20c, 1'h1);
    endtask
    // back-to-back breakpoints, then prefixed forms that must be refused
    task automatic t_brk;
        issue(32'hefe5, 32'h4000);
        chk({31'h0, brk_o}, 32'h1);
        chk(brk_pc_o, 32'h4000);
        issue(32'hefe5, 32'h4002);
        chk({31'h0, brk_o}, 32'h1);
        chk(brk_pc_o, 32'h4002);
        issue(32'hf000_efe5, 32'h4004);
        chk({31'h0, unknown_o}, 32'h1);
        issue(32'hf010_2221, 32'h300);
        chk({30'h0, unknown_o, rd_en_o}, 32'h2);
        inst_valid_i = 1'h0;
        @(negedge clk_i);
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        nrst_i = 1'h1;
        @(negedge clk_i);
        chk({31'h0, ready_o}, 32'h1);
        t_cond;
        t_ext;
        t_brk;
        stop_test;
    end
    // the tests need well under 200 cycles
    initial begin
        repeat (2000) @(posedge clk_i);
        mismatches++;
        stop_test;
    end
endmodule // czb_branch_unit_bench
`default_nettype wire
